/* bmu_bit_unit.sv */
// Bit manipulation datapath: carry logic, register-direct ops, memory read-modify-write.
// Assumes the core holds opValid high for one cycle and waits for done; the bus replies
// to a read in the next cycle through the port register block.
`include "bmu_regs.svh"

// What this block does
// - Inverted-bit xor: carry becomes carry xor not selected bit.
// - Load bit: carry takes selected bit; operand untouched.
// - Load inverted bit: carry takes complement of selected bit.
// - Store carry: selected bit of operand takes carry.
// - Store inverted carry: selected bit takes complement of carry.
// - Inverted forms take bit number from 3-bit immediate only.
// - Set, clear, invert, store forms rewrite whole byte, one bit changed.
// - Read byte at operand address, write modified byte to same address.
// - Direction register reads as all ones; rewrite sets other bits.
// - Data register read returns pin level for input pins.
// - Data register read returns stored bit for output pins.
// - Direction bit 0 makes pin input, 1 makes it output.
// - Data bit of input pin drives its pull-up: 1 on, 0 off.
// - Set, clear, invert, test take bit from immediate or register low bits.
// - Invert complements, set forces one, clear forces zero.
module bmu_bit_unit
	import bmu_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic opValid,
	input wire bmu_pkg::bmu_op_t opCode,
	input wire logic opIsReg,
	input wire logic bitFromReg,
	input wire logic [2:0] bitImm,
	input wire bmu_pkg::bmu_byte_t bitRegVal,
	input wire bmu_pkg::bmu_byte_t regOperand,
	input wire bmu_pkg::bmu_addr_t opAddr,
	input wire logic carryIn,
	input wire bmu_pkg::bmu_byte_t memRdData,
	input wire bmu_pkg::bmu_byte_t pinIn,
	output logic busRd_reg,
	output logic busWr_reg,
	output bmu_pkg::bmu_addr_t busAddr_reg,
	output bmu_pkg::bmu_byte_t busWrData_reg,
	output bmu_pkg::bmu_byte_t regResult_reg,
	output logic regWr_reg,
	output logic carryOut_reg,
	output logic carryWr_reg,
	output logic zeroOut_reg,
	output logic zeroWr_reg,
	output logic done_reg,
	output bmu_pkg::bmu_byte_t portDir_reg,
	output bmu_pkg::bmu_byte_t portOut_reg,
	output bmu_pkg::bmu_byte_t pullUpEn_reg
);
	bmu_state_t state_reg, state_next;
	bmu_op_t op_reg;
	logic [2:0] bitNum_reg;
	logic carry_reg;
	bmu_byte_t rdData;
	bmu_byte_t ddrVal;
	bmu_byte_t drVal;

	function automatic bmu_byte_t modify_byte(input bmu_op_t op, input bmu_byte_t d,
		input logic [2:0] n, input logic c);
		bmu_byte_t m;
		m = 8'h01 << n;
		case (op)
			`BMU_OP_SET: modify_byte = d | m;
			`BMU_OP_CLR: modify_byte = d & ~m;
			`BMU_OP_NOT: modify_byte = d ^ m;
			`BMU_OP_ST: modify_byte = c ? (d | m) : (d & ~m);
			`BMU_OP_IST: modify_byte = c ? (d & ~m) : (d | m);
			default: modify_byte = d;
		endcase
	endfunction

	function automatic logic writes_back(input bmu_op_t op);
		writes_back = (op == `BMU_OP_SET) || (op == `BMU_OP_CLR) || (op == `BMU_OP_NOT)
			|| (op == `BMU_OP_ST) || (op == `BMU_OP_IST);
	endfunction

	// Inverted forms have no register bit-number encoding, so the select is ignored
	wire isInvForm = (opCode == `BMU_OP_ILD) || (opCode == `BMU_OP_IST)
		|| (opCode == `BMU_OP_IXOR);
	wire useRegBit = bitFromReg && !isInvForm && ((opCode == `BMU_OP_SET)
		|| (opCode == `BMU_OP_CLR) || (opCode == `BMU_OP_NOT) || (opCode == `BMU_OP_TST));
	wire [2:0] bitSel = useRegBit ? bitRegVal[2:0] : bitImm;
	wire startReg = (state_reg == BMU_IDLE) && opValid && opIsReg;
	wire startMem = (state_reg == BMU_IDLE) && opValid && !opIsReg;
	wire bmu_byte_t operand = (state_reg == BMU_MODIFY) ? rdData : regOperand;
	wire bmu_op_t opNow = (state_reg == BMU_MODIFY) ? op_reg : opCode;
	wire [2:0] bitNow = (state_reg == BMU_MODIFY) ? bitNum_reg : bitSel;
	wire selBit = operand[bitNow];
	wire evalNow = startReg || (state_reg == BMU_MODIFY);
	wire isCarryOp = (opNow == `BMU_OP_LD) || (opNow == `BMU_OP_ILD) || (opNow == `BMU_OP_IXOR);
	// Memory ops use the carry taken at start, so a flag change during the read cannot leak in
	wire carryNow = (state_reg == BMU_MODIFY) ? carry_reg : carryIn;
	wire carryNext = (opNow == `BMU_OP_LD) ? selBit
		: (opNow == `BMU_OP_ILD) ? ~selBit
		: (carryNow ^ ~selBit);
	wire bmu_byte_t newByte = modify_byte(opNow, operand, bitNow, carryNow);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			BMU_IDLE: begin
				if (startMem) begin
					state_next = BMU_READ;
				end else if (startReg) begin
					state_next = BMU_DONE;
				end
			end
			BMU_READ: state_next = BMU_MODIFY;
			BMU_MODIFY: state_next = writes_back(op_reg) ? BMU_WRITE : BMU_DONE;
			BMU_WRITE: state_next = BMU_DONE;
			BMU_DONE: state_next = BMU_IDLE;
			default: state_next = BMU_IDLE;
		endcase
	end

	bmu_port_regs bmu_port_regs_i (
		.clk(clk),
		.sys_rst(sys_rst),
		.wrEn(busWr_reg),
		.addr(busAddr_reg),
		.wrData(busWrData_reg),
		.memRdData(memRdData),
		.pinIn(pinIn),
		.rdData_reg(rdData),
		.ddr_reg(ddrVal),
		.dr_reg(drVal)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= BMU_IDLE;
			op_reg <= `BMU_OP_NONE;
			bitNum_reg <= 3'h0;
			carry_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (startMem) begin
				op_reg <= opCode;
				bitNum_reg <= bitSel;
				carry_reg <= carryIn;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busRd_reg <= 1'b0;
			busWr_reg <= 1'b0;
			busAddr_reg <= 16'h0000;
			busWrData_reg <= 8'h00;
		end else begin
			busRd_reg <= startMem;
			busWr_reg <= (state_reg == BMU_MODIFY) && writes_back(op_reg);
			if (startMem) begin
				busAddr_reg <= opAddr;
			end
			if (state_reg == BMU_MODIFY) begin
				busWrData_reg <= newByte;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regResult_reg <= 8'h00;
			regWr_reg <= 1'b0;
			carryOut_reg <= 1'b0;
			carryWr_reg <= 1'b0;
			zeroOut_reg <= 1'b0;
			zeroWr_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			regWr_reg <= startReg && writes_back(opCode);
			if (startReg) begin
				regResult_reg <= newByte;
			end
			carryWr_reg <= evalNow && isCarryOp;
			if (evalNow && isCarryOp) begin
				carryOut_reg <= carryNext;
			end
			zeroWr_reg <= evalNow && (opNow == `BMU_OP_TST);
			if (evalNow && (opNow == `BMU_OP_TST)) begin
				zeroOut_reg <= ~selBit;
			end
			done_reg <= state_next == BMU_DONE;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			portDir_reg <= 8'h00;
			portOut_reg <= 8'h00;
			pullUpEn_reg <= 8'h00;
		end else begin
			portDir_reg <= ddrVal;
			portOut_reg <= drVal & ddrVal;
			pullUpEn_reg <= drVal & ~ddrVal;
		end
	end

	AST_REG_NO_BUS: assert property (@(posedge clk) disable iff (sys_rst)
		startReg |=> !busRd_reg ##1 !busWr_reg) else $error("bus used for register op");
	AST_RMW_SEQ: assert property (@(posedge clk) disable iff (sys_rst)
		startMem && writes_back(opCode) |=> busRd_reg ##2 busWr_reg)
		else $error("read-modify-write order broken");
	AST_SAME_ADDR: assert property (@(posedge clk) disable iff (sys_rst)
		busRd_reg |-> ##2 (busAddr_reg == $past(busAddr_reg, 2))) else $error("address moved");
	AST_LD_CARRY: assert property (@(posedge clk) disable iff (sys_rst)
		startReg && opCode == `BMU_OP_LD |=> carryWr_reg && carryOut_reg == $past(selBit))
		else $error("load bit carry wrong");
	AST_ILD_CARRY: assert property (@(posedge clk) disable iff (sys_rst)
		startReg && opCode == `BMU_OP_ILD |=> carryOut_reg == !$past(selBit))
		else $error("load inverted carry wrong");
	AST_IXOR_CARRY: assert property (@(posedge clk) disable iff (sys_rst)
		startReg && opCode == `BMU_OP_IXOR |=> carryOut_reg == ($past(carryIn) ^ !$past(selBit)))
		else $error("xor inverted carry wrong");
	AST_IMM_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
		opValid && isInvForm |-> bitSel == bitImm)
		else $error("inverted form used register bit");
	AST_ST_BIT: assert property (@(posedge clk) disable iff (sys_rst)
		startReg && opCode == `BMU_OP_ST |=> regResult_reg[$past(bitSel)] == $past(carryIn))
		else $error("store carry wrong");
	AST_IST_BIT: assert property (@(posedge clk) disable iff (sys_rst)
		startReg && opCode == `BMU_OP_IST |=> regResult_reg[$past(bitSel)] == !$past(carryIn))
		else $error("store inverted carry wrong");
	AST_PULLUP: assert property (@(posedge clk) disable iff (sys_rst)
		##1 pullUpEn_reg == ($past(drVal) & ~$past(ddrVal))) else $error("pull-up wrong");

	COV_REG_OP: cover property (@(posedge clk) startReg);
	COV_MEM_RMW: cover property (@(posedge clk) busRd_reg ##2 busWr_reg);
	COV_DDR_RMW: cover property (@(posedge clk) busWr_reg && busAddr_reg == `BMU_PORT_DDR_ADDR);
	COV_DR_RMW: cover property (@(posedge clk) busWr_reg && busAddr_reg == `BMU_PORT_DR_ADDR);
endmodule

/* bmu_regs.svh */
// Constants of the bit manipulation unit: opcodes, port register addresses, reset values.
// Assumes it is included once per compile unit by the package and the modules.
`ifndef BMU_REGS_SVH
`define BMU_REGS_SVH
`define BMU_OP_W 4
`define BMU_OP_NONE 4'h0
`define BMU_OP_SET 4'h1
`define BMU_OP_CLR 4'h2
`define BMU_OP_NOT 4'h3
`define BMU_OP_TST 4'h4
`define BMU_OP_LD 4'h5
`define BMU_OP_ILD 4'h6
`define BMU_OP_ST 4'h7
`define BMU_OP_IST 4'h8
`define BMU_OP_IXOR 4'h9
`define BMU_ADDR_W 16
`define BMU_PORT_DDR_ADDR 16'hFFC5
`define BMU_PORT_DR_ADDR 16'hFFC7
`define BMU_DDR_READ_VAL 8'hFF
`define BMU_DDR_RESET 8'h00
`define BMU_DR_RESET 8'h00
`endif

/* bmu_pkg.sv */
// Types of the bit manipulation unit.
// Assumes bmu_regs.svh sits in the include path.
`include "bmu_regs.svh"
package bmu_pkg;
	typedef logic [`BMU_OP_W-1:0] bmu_op_t;
	typedef logic [`BMU_ADDR_W-1:0] bmu_addr_t;
	typedef logic [7:0] bmu_byte_t;
	typedef enum logic [4:0] {
		BMU_IDLE = 5'h01,
		BMU_READ = 5'h02,
		BMU_MODIFY = 5'h04,
		BMU_WRITE = 5'h08,
		BMU_DONE = 5'h10
	} bmu_state_t;
endpackage

/* bmu_port_regs.sv */
// Port data and direction registers with their read-back behaviour.
// Assumes one bus access per cycle from the unit; pin levels are synchronous.
`include "bmu_regs.svh"
module bmu_port_regs
	import bmu_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wrEn,
	input wire bmu_pkg::bmu_addr_t addr,
	input wire bmu_pkg::bmu_byte_t wrData,
	input wire bmu_pkg::bmu_byte_t memRdData,
	input wire bmu_pkg::bmu_byte_t pinIn,
	output bmu_pkg::bmu_byte_t rdData_reg,
	output bmu_pkg::bmu_byte_t ddr_reg,
	output bmu_pkg::bmu_byte_t dr_reg
);
	wire isDdr = (addr == `BMU_PORT_DDR_ADDR);
	wire isDr = (addr == `BMU_PORT_DR_ADDR);
	// Inputs give pin level, outputs give the stored bit
	wire bmu_byte_t drView = (pinIn & ~ddr_reg) | (dr_reg & ddr_reg);
	wire bmu_byte_t rdNext = isDdr ? `BMU_DDR_READ_VAL : (isDr ? drView : memRdData);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ddr_reg <= `BMU_DDR_RESET;
			dr_reg <= `BMU_DR_RESET;
			rdData_reg <= 8'h00;
		end else begin
			rdData_reg <= rdNext;
			if (wrEn && isDdr) begin
				ddr_reg <= wrData;
			end
			if (wrEn && isDr) begin
				dr_reg <= wrData;
			end
		end
	end

	AST_DDR_READS_ONES: assert property (@(posedge clk) disable iff (sys_rst)
		isDdr |=> rdData_reg == 8'hFF) else $error("direction read not all ones");
	// Judged bit by bit against pins and stored bits, not against the read mux itself
	AST_DR_VIEW: assert property (@(posedge clk) disable iff (sys_rst)
		isDr |=> ((rdData_reg ^ $past(pinIn)) & ~$past(ddr_reg)) == 8'h00)
		else $error("input pin not read as pin level");
	AST_DR_OUT_VIEW: assert property (@(posedge clk) disable iff (sys_rst)
		isDr |=> ((rdData_reg ^ $past(dr_reg)) & $past(ddr_reg)) == 8'h00)
		else $error("output pin not read as stored bit");
endmodule

/* bmu_mem_model.sv */
// Behavioural memory on the unit's bus: combinational read reply, write at the clock edge.
// Assumes one strobe per cycle; the low address byte picks the cell.
module bmu_mem_model
	import bmu_pkg::*;
(
	input wire logic clk,
	input wire logic busRd_reg,
	input wire logic busWr_reg,
	input wire bmu_pkg::bmu_addr_t busAddr_reg,
	input wire bmu_pkg::bmu_byte_t busWrData_reg,
	output bmu_pkg::bmu_byte_t memRdData
);
	timeunit 1ns;
	timeprecision 1ns;
	bmu_byte_t mem [0:255];
	bmu_byte_t lastRd;
	// Outside a read the lines show the inverse, so a late sample cannot pass by luck
	assign memRdData = busRd_reg ? mem[busAddr_reg[7:0]] : ~lastRd;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
		lastRd = 8'h00;
	end
	always @(posedge clk) begin
		if (busRd_reg) begin
			lastRd <= memRdData;
		end
		if (busWr_reg) begin
			mem[busAddr_reg[7:0]] <= busWrData_reg;
		end
	end
endmodule

/* test_bit_manipulation_unit.sv */
// Bench for the bit unit: register ops, memory read-modify-write, port read-back.
// Assumes the memory model answers reads on the same bus in the strobe cycle.
`include "bmu_regs.svh"
module test_bit_manipulation_unit;
	timeunit 1ns;
	timeprecision 1ns;
	import bmu_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, opValid = 1'b0, opIsReg = 1'b0;
	logic bitFromReg = 1'b0, carryIn = 1'b0;
	logic [2:0] bitImm = 3'h0;
	bmu_op_t opCode = `BMU_OP_NONE;
	bmu_byte_t bitRegVal = 8'h00, regOperand = 8'hA5, pinIn = 8'h00, memRdData;
	bmu_addr_t opAddr = 16'h0000, busAddr_reg, rdA, wrA;
	bmu_byte_t busWrData_reg, regResult_reg, portDir_reg, portOut_reg, pullUpEn_reg, wrD, gotR;
	logic busRd_reg, busWr_reg, regWr_reg, carryOut_reg, carryWr_reg, zeroOut_reg, zeroWr_reg;
	logic done_reg, gotC, gotZ;
	int n_fail = 0, n_compared = 0, nRd, nWr, k;
	bmu_bit_unit bmu_bit_unit_i (.clk, .sys_rst, .opValid, .opCode, .opIsReg, .bitFromReg,
		.bitImm, .bitRegVal, .regOperand, .opAddr, .carryIn, .memRdData, .pinIn, .busRd_reg,
		.busWr_reg, .busAddr_reg, .busWrData_reg, .regResult_reg, .regWr_reg, .carryOut_reg,
		.carryWr_reg, .zeroOut_reg, .zeroWr_reg, .done_reg, .portDir_reg, .portOut_reg,
		.pullUpEn_reg);
	bmu_mem_model bmu_mem_model_i (.clk, .busRd_reg, .busWr_reg, .busAddr_reg, .busWrData_reg,
		.memRdData);
	always #25 clk = ~clk;
	task automatic chkb(input bmu_byte_t g, input bmu_byte_t e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chka(input bmu_addr_t g, input bmu_addr_t e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chkf(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Inverted forms always see the register path enabled; with fr low it points at a wrong bit
	task automatic op(input bmu_op_t c, input logic [2:0] b, input logic fr, input logic r,
			input bmu_addr_t a, input logic ci);
		@(posedge clk);
		opValid <= 1'b1;
		opCode <= c;
		opIsReg <= r;
		bitImm <= fr ? ~b : b;
		bitRegVal <= {5'h15, fr ? b : ~b};
		bitFromReg <= fr | (c == `BMU_OP_ILD) | (c == `BMU_OP_IST) | (c == `BMU_OP_IXOR);
		opAddr <= a;
		carryIn <= ci;
		@(posedge clk);
		opValid <= 1'b0;
		{nRd, nWr, k} = '0;
		{gotC, gotZ, gotR} = 'x;
		do begin
			@(negedge clk);
			k++;
			nRd += int'(busRd_reg === 1'b1);
			nWr += int'(busWr_reg === 1'b1);
			if (busRd_reg === 1'b1) rdA = busAddr_reg;
			if (busWr_reg === 1'b1) {wrA, wrD} = {busAddr_reg, busWrData_reg};
			if (carryWr_reg === 1'b1) gotC = carryOut_reg;
			if (zeroWr_reg === 1'b1) gotZ = zeroOut_reg;
			if (regWr_reg === 1'b1) gotR = regResult_reg;
		end while (done_reg !== 1'b1 && k < 12);
		chkf(done_reg, 1'b1);
	endtask
	task automatic judge(input bmu_op_t c, input bmu_byte_t e);
		if (c inside {`BMU_OP_LD, `BMU_OP_ILD, `BMU_OP_IXOR}) chkf(gotC, e[0]);
		else if (c == `BMU_OP_TST) chkf(gotZ, e[0]);
		else if (opIsReg) chkb(gotR, e);
		else chkb(wrD, e);
	endtask
	task automatic reg_case(input bmu_op_t c, input logic [2:0] b, input logic fr,
			input logic ci, input bmu_byte_t e);
		op(c, b, fr, 1'b1, 16'h0000, ci);
		chkb(8'(nRd + nWr), 8'h00);
		judge(c, e);
	endtask
	task automatic mem_case(input bmu_op_t c, input logic [2:0] b, input bmu_addr_t a,
			input logic ci, input bmu_byte_t e);
		op(c, b, 1'b0, 1'b0, a, ci);
		chka(rdA, a);
		judge(c, e);
		if (c inside {`BMU_OP_LD, `BMU_OP_ILD, `BMU_OP_IXOR, `BMU_OP_TST}) begin
			chkb(8'(nRd * 16 + nWr), 8'h10);
		end else begin
			chkb(8'(nRd * 16 + nWr), 8'h11);
			chka(wrA, a);
		end
	endtask
	task automatic t_reg();
		reg_case(`BMU_OP_SET, 3'h1, 1'b1, 1'b0, 8'hA7);
		reg_case(`BMU_OP_CLR, 3'h7, 1'b0, 1'b0, 8'h25);
		reg_case(`BMU_OP_NOT, 3'h0, 1'b1, 1'b0, 8'hA4);
		reg_case(`BMU_OP_TST, 3'h1, 1'b1, 1'b0, 8'h01);
		reg_case(`BMU_OP_LD, 3'h2, 1'b0, 1'b0, 8'h01);
		reg_case(`BMU_OP_ILD, 3'h2, 1'b0, 1'b1, 8'h00);
		reg_case(`BMU_OP_IXOR, 3'h6, 1'b0, 1'b1, 8'h00);
		reg_case(`BMU_OP_ST, 3'h6, 1'b0, 1'b1, 8'hE5);
		reg_case(`BMU_OP_IST, 3'h0, 1'b0, 1'b1, 8'hA4);
	endtask
	task automatic t_mem();
		mem_case(`BMU_OP_SET, 3'h0, 16'h0010, 1'b0, 8'h4B);
		mem_case(`BMU_OP_ST, 3'h2, 16'h0010, 1'b1, 8'h4F);
		mem_case(`BMU_OP_IST, 3'h0, 16'h0010, 1'b1, 8'h4E);
		mem_case(`BMU_OP_NOT, 3'h7, 16'h0010, 1'b0, 8'hCE);
		mem_case(`BMU_OP_CLR, 3'h6, 16'h0010, 1'b0, 8'h8E);
		mem_case(`BMU_OP_LD, 3'h7, 16'h0010, 1'b0, 8'h01);
		mem_case(`BMU_OP_ILD, 3'h7, 16'h0010, 1'b1, 8'h00);
		mem_case(`BMU_OP_IXOR, 3'h1, 16'h0010, 1'b1, 8'h01);
		mem_case(`BMU_OP_TST, 3'h4, 16'h0010, 1'b0, 8'h01);
	endtask
	task automatic t_port();
		mem_case(`BMU_OP_SET, 3'h0, `BMU_PORT_DDR_ADDR, 1'b0, 8'hFF);
		mem_case(`BMU_OP_CLR, 3'h0, `BMU_PORT_DDR_ADDR, 1'b0, 8'hFE);
		@(posedge clk);
		pinIn <= 8'h01;
		repeat (3) @(posedge clk);
		mem_case(`BMU_OP_CLR, 3'h7, `BMU_PORT_DR_ADDR, 1'b0, 8'h01);
		repeat (2) @(negedge clk);
		chkb(portDir_reg, 8'hFE);
		chkb(pullUpEn_reg, 8'h01);
		chkb(portOut_reg, 8'h00);
		@(posedge clk);
		pinIn <= 8'h00;
		repeat (3) @(posedge clk);
		mem_case(`BMU_OP_SET, 3'h1, `BMU_PORT_DR_ADDR, 1'b0, 8'h02);
		mem_case(`BMU_OP_SET, 3'h2, `BMU_PORT_DR_ADDR, 1'b0, 8'h06);
		repeat (2) @(negedge clk);
		chkb(pullUpEn_reg, 8'h00);
		chkb(portOut_reg, 8'h06);
	endtask
	task automatic print_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chkb(portDir_reg, 8'h00);
		t_reg();
		t_mem();
		t_port();
		print_verdict();
	end
endmodule
